// File: logic/datp_consts.svh
// Constants for the data port byte lane block
`ifndef DATP_CONSTS_SVH
`define DATP_CONSTS_SVH

`define DATP_ASCII_LO 8'h20
`define DATP_ASCII_HI 8'h7e
`define DATP_ASCII_SUB 8'h20
`define DATP_BIN_PAD 8'h00
`define DATP_LEN_ZERO 16'h0000
`define DATP_LEN_ONE 16'h0001
`define DATP_WORD_ZERO 16'h0000

`endif

// File: logic/datp_pack.sv
// Byte to word lane packer for the data port
`timescale 1ns/10ps
`include "datp_consts.svh"

module datp_pack (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Control
  input wire logic clr,
  input wire logic take,
  input wire logic pop,
  input wire logic wide,
  input wire logic ascii,
  input wire logic last,
  input wire logic [7:0] byte_in,
  // Result
  output logic [15:0] word,
  output logic full,
  output logic lane
);

  datp_pkg::datp_pack_st_t st;
  datp_pkg::datp_pack_st_t next_st;

  // Lane placement and fill state
  always_comb begin
    next_st = st;
    if (pop) begin
      next_st.full = 1'b0;
      next_st.lane = 1'b0;
    end
    if (take) begin
      if (!wide) begin
        next_st.word = {`DATP_BIN_PAD, byte_in}; // [R8]
        next_st.full = 1'b1;
      end else if (!st.lane) begin
        // First byte of a word; unused half holds the pad value
        if (ascii) begin
          next_st.word = {byte_in, `DATP_ASCII_SUB}; // [R10]
        end else begin
          next_st.word = {`DATP_BIN_PAD, byte_in}; // [R7]
        end
        next_st.lane = 1'b1;
        next_st.full = last;
      end else begin
        if (ascii) begin
          next_st.word[7:0] = byte_in; // [R10]
        end else begin
          next_st.word[15:8] = byte_in; // [R7]
        end
        next_st.lane = 1'b0;
        next_st.full = 1'b1;
      end
    end
    if (clr) begin
      next_st.lane = 1'b0; // [R11]
      next_st.full = 1'b0;
    end
    if (srst) begin
      next_st.lane = 1'b0;
      next_st.word = `DATP_WORD_ZERO;
      next_st.full = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    st <= next_st;
  end

  assign word = st.word;
  assign full = st.full;
  assign lane = st.lane;

  // Lane checks
  even_low_lane_a: assert property (@(posedge clk) disable iff (srst) // [R7]
    take && wide && !ascii && !st.lane && !clr |=> st.word[7:0] == $past(byte_in))
    else $error("even byte not on low lane");
  odd_high_lane_a: assert property (@(posedge clk) disable iff (srst) // [R7]
    take && wide && !ascii && st.lane && !clr |=> st.word[15:8] == $past(byte_in) && st.full)
    else $error("odd byte not on high lane");
  narrow_byte_a: assert property (@(posedge clk) disable iff (srst) // [R8]
    take && !wide && !clr |=> st.full && st.word == {`DATP_BIN_PAD, $past(byte_in)})
    else $error("narrow transfer not one low byte");
  string_swap_a: assert property (@(posedge clk) disable iff (srst) // [R10]
    take && wide && ascii && !st.lane && !clr |=> st.word[15:8] == $past(byte_in))
    else $error("string first char not on high lane");
  restart_lane_a: assert property (@(posedge clk) disable iff (srst) // [R11]
    clr |=> !st.lane && !st.full)
    else $error("lane index not restarted");

endmodule : datp_pack

// File: logic/datp_pkg.sv
// Types for the data port byte lane block
package datp_pkg;

  typedef enum logic [1:0] {
    DATP_MODE_PIO16 = 2'b00,
    DATP_MODE_PIO8 = 2'b01,
    DATP_MODE_DMA = 2'b10
  } datp_mode_t;

  typedef enum logic [1:0] {
    DATP_IDLE = 2'b00,
    DATP_FILL = 2'b01,
    DATP_PRESENT = 2'b10
  } datp_state_t;

  typedef struct packed {
    datp_state_t state;
    datp_mode_t mode;
    logic ascii;
    logic [15:0] remain;
    logic bsy;
    logic drq;
    logic dmarq;
    logic [15:0] dd_out;
    logic dd_oe_n;
    logic in_ready;
    logic char_err;
    logic done;
    logic stb_s1;
    logic stb_s2;
    logic stb_s3;
    logic ack_s1;
    logic ack_s2;
  } datp_port_st_t;

  typedef struct packed {
    logic lane;
    logic [15:0] word;
    logic full;
  } datp_pack_st_t;

endpackage : datp_pkg

// File: logic/datp_port.sv
// Device end of the parallel data port: byte lane order, PIO and DMA
//
// Function
// R1 - PIO word moves only when ready and requesting
// R2 - PIO is 16-bit; optional 8-bit low lane
// R3 - DMA moves only with request and acknowledge
// R4 - DMA always uses full 16-bit width
// R5 - Each acknowledge is a burst, one word minimum
// R6 - A DRQ block holds at least one byte
// R7 - Even byte low lane, odd byte high
// R8 - 8-bit PIO: one byte, low lane, ascending
// R9 - String characters only 20h through 7Eh
// R10 - Strings: earlier character on high lane
// R11 - Byte index restarts each block or burst
`timescale 1ns/10ps
`include "datp_consts.svh"

module datp_port (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Block request from the device core
  input wire logic blk_start,
  input wire logic [15:0] blk_len,
  input wire datp_pkg::datp_mode_t blk_mode,
  input wire logic blk_ascii,
  // Byte stream from the device core
  input wire logic [7:0] in_byte,
  input wire logic in_valid,
  output logic in_ready,
  // Host pins, asynchronous
  input wire logic hstb_n,
  input wire logic dmack_n,
  // Device pins
  output logic [15:0] dd_out,
  output logic dd_oe_n,
  output logic bsy,
  output logic drq,
  output logic dmarq,
  // Status to the device core
  output logic blk_done,
  output logic char_err
);

  datp_pkg::datp_port_st_t st;
  datp_pkg::datp_port_st_t next_st;
  logic [15:0] pk_word;
  logic pk_full;
  logic pk_lane;
  logic pk_clr;
  logic take;
  logic wide;
  logic last;
  logic stb_fall;
  logic xfer;
  logic [7:0] clean_byte;

  // Printable string character check
  function automatic logic datp_printable(input logic [7:0] b);
    datp_printable = (b >= `DATP_ASCII_LO) && (b <= `DATP_ASCII_HI);
  endfunction : datp_printable

  // Control terms shared by the packer and the state update
  always_comb begin
    take = st.in_ready && in_valid;
    wide = (st.mode != datp_pkg::DATP_MODE_PIO8); // [R2] [R4]
    last = (st.remain == `DATP_LEN_ONE);
    pk_clr = (st.state == datp_pkg::DATP_IDLE) && blk_start; // [R11]
    stb_fall = !st.stb_s2 && st.stb_s3;
    if (st.mode == datp_pkg::DATP_MODE_DMA) begin
      xfer = (st.state == datp_pkg::DATP_PRESENT) && st.dmarq && !st.ack_s2 && stb_fall; // [R3]
    end else begin
      xfer = (st.state == datp_pkg::DATP_PRESENT) && st.drq && !st.bsy && stb_fall; // [R1]
    end
    // Out of range string characters become spaces
    if (st.ascii && !datp_printable(in_byte)) begin
      clean_byte = `DATP_ASCII_SUB; // [R9]
    end else begin
      clean_byte = in_byte;
    end
  end

  // Lane packer
  datp_pack u_pack (
    .clk(clk),
    .srst(srst),
    .clr(pk_clr),
    .take(take),
    .pop(xfer),
    .wide(wide),
    .ascii(st.ascii),
    .last(last),
    .byte_in(clean_byte),
    .word(pk_word),
    .full(pk_full),
    .lane(pk_lane)
  );

  // Next state
  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    // Two flop synchronisers plus one edge stage
    next_st.stb_s1 = hstb_n;
    next_st.stb_s2 = st.stb_s1;
    next_st.stb_s3 = st.stb_s2;
    next_st.ack_s1 = dmack_n;
    next_st.ack_s2 = st.ack_s1;
    case (st.state)
      datp_pkg::DATP_IDLE: begin
        next_st.bsy = 1'b1;
        next_st.drq = 1'b0;
        next_st.dmarq = 1'b0;
        next_st.dd_oe_n = 1'b1;
        // Empty blocks are dropped
        if (blk_start && blk_len != `DATP_LEN_ZERO) begin // [R6]
          next_st.mode = blk_mode;
          next_st.ascii = blk_ascii;
          next_st.remain = blk_len;
          next_st.char_err = 1'b0;
          next_st.in_ready = 1'b1;
          next_st.state = datp_pkg::DATP_FILL;
        end
      end
      datp_pkg::DATP_FILL: begin
        if (take) begin
          next_st.remain = st.remain - `DATP_LEN_ONE;
          if (st.ascii && !datp_printable(in_byte)) begin
            next_st.char_err = 1'b1;
          end
          // Word complete: stop taking and present it
          if (!wide || pk_lane || last) begin
            next_st.in_ready = 1'b0;
            next_st.state = datp_pkg::DATP_PRESENT;
          end
        end
      end
      datp_pkg::DATP_PRESENT: begin
        next_st.dd_out = pk_word;
        if (st.mode == datp_pkg::DATP_MODE_DMA) begin
          next_st.dmarq = 1'b1; // [R3]
          next_st.dd_oe_n = st.ack_s2;
        end else begin
          next_st.bsy = 1'b0; // [R1]
          next_st.drq = 1'b1;
          next_st.dd_oe_n = 1'b0;
        end
        // Word taken by the host; request stays up until then
        if (xfer) begin // [R5]
          next_st.bsy = 1'b1;
          next_st.drq = 1'b0;
          next_st.dmarq = 1'b0;
          next_st.dd_oe_n = 1'b1;
          if (st.remain == `DATP_LEN_ZERO) begin
            next_st.done = 1'b1;
            next_st.state = datp_pkg::DATP_IDLE;
          end else begin
            next_st.in_ready = 1'b1;
            next_st.state = datp_pkg::DATP_FILL;
          end
        end
      end
      default: begin
        next_st.state = datp_pkg::DATP_IDLE;
      end
    endcase
    if (srst) begin
      next_st.state = datp_pkg::DATP_IDLE;
      next_st.mode = datp_pkg::DATP_MODE_PIO16;
      next_st.ascii = 1'b0;
      next_st.remain = `DATP_LEN_ZERO;
      next_st.bsy = 1'b1;
      next_st.drq = 1'b0;
      next_st.dmarq = 1'b0;
      next_st.dd_out = `DATP_WORD_ZERO;
      next_st.dd_oe_n = 1'b1;
      next_st.in_ready = 1'b0;
      next_st.char_err = 1'b0;
      next_st.done = 1'b0;
      next_st.stb_s1 = 1'b1;
      next_st.stb_s2 = 1'b1;
      next_st.stb_s3 = 1'b1;
      next_st.ack_s1 = 1'b1;
      next_st.ack_s2 = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    st <= next_st;
  end

  // Outputs come straight from the state register
  assign in_ready = st.in_ready;
  assign dd_out = st.dd_out;
  assign dd_oe_n = st.dd_oe_n;
  assign bsy = st.bsy;
  assign drq = st.drq;
  assign dmarq = st.dmarq;
  assign blk_done = st.done;
  assign char_err = st.char_err;

  // Protocol checks
  pio_move_gate_a: assert property (@(posedge clk) disable iff (srst) // [R1]
    xfer && st.mode != datp_pkg::DATP_MODE_DMA |-> drq && !bsy ##1 !drq && bsy)
    else $error("PIO word moved outside ready and request");
  narrow_upper_zero_a: assert property (@(posedge clk) disable iff (srst) // [R2]
    drq && st.mode == datp_pkg::DATP_MODE_PIO8 |-> dd_out[15:8] == `DATP_BIN_PAD)
    else $error("8-bit PIO drove the high lane");
  dma_move_gate_a: assert property (@(posedge clk) disable iff (srst) // [R3]
    !dd_oe_n && st.mode == datp_pkg::DATP_MODE_DMA |-> dmarq && !$past(st.ack_s2))
    else $error("DMA data driven without both handshakes");
  dma_full_width_a: assert property (@(posedge clk) disable iff (srst) // [R4]
    dmarq |-> st.mode == datp_pkg::DATP_MODE_DMA && !drq && wide)
    else $error("DMA request outside 16-bit DMA mode");
  dma_request_holds_a: assert property (@(posedge clk) disable iff (srst) // [R5]
    dmarq && !xfer |=> dmarq)
    else $error("DMA request dropped before a word moved");
  block_has_byte_a: assert property (@(posedge clk) disable iff (srst) // [R6]
    $rose(st.state == datp_pkg::DATP_PRESENT) |-> pk_full ##1 (drq || dmarq))
    else $error("request raised with no byte gathered");
  string_printable_a: assert property (@(posedge clk) disable iff (srst) // [R9]
    !dd_oe_n && st.ascii |-> datp_printable(dd_out[15:8]) && datp_printable(dd_out[7:0]))
    else $error("string character out of printable range");
  word_order_a: assert property (@(posedge clk) disable iff (srst) // [R7]
    $rose(st.state == datp_pkg::DATP_PRESENT) |=> dd_out == $past(pk_word))
    else $error("presented word differs from packed word");
  block_restart_a: assert property (@(posedge clk) disable iff (srst) // [R11]
    pk_clr |=> !pk_lane && st.remain == $past(blk_len) || $past(blk_len) == `DATP_LEN_ZERO)
    else $error("block did not restart at byte zero");

  // Main scenarios
  pio16_word_c: cover property (@(posedge clk) disable iff (srst)
    xfer && st.mode == datp_pkg::DATP_MODE_PIO16);
  pio8_byte_c: cover property (@(posedge clk) disable iff (srst)
    xfer && st.mode == datp_pkg::DATP_MODE_PIO8);
  dma_word_c: cover property (@(posedge clk) disable iff (srst)
    xfer && st.mode == datp_pkg::DATP_MODE_DMA);
  string_block_c: cover property (@(posedge clk) disable iff (srst)
    st.done && st.ascii);

endmodule : datp_port

// File: tb/datp_host.sv
// Host side model that strobes words out of the device data port
`timescale 1ns/10ps

module datp_host (
  // Clock
  input wire logic clk,
  // Device pins
  input wire logic [15:0] dd_out,
  input wire logic dd_oe_n,
  input wire logic bsy,
  input wire logic drq,
  input wire logic dmarq,
  // Host pins
  output logic hstb_n,
  output logic dmack_n,
  // Bench control: hold acknowledge across words, answer late
  input wire logic burst,
  input wire logic slow
);
  logic [15:0] got[$];
  int oe_bad;

  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_n

  // One word: take it at the strobe fall, hold low and high three cycles each
  task automatic strobe();
    if (dd_oe_n !== 1'b0) oe_bad++;
    got.push_back(dd_out);
    hstb_n = 1'b0;
    wait_n(3);
    hstb_n = 1'b1;
    wait_n(3);
  endtask : strobe

  // Pins idle high from time zero, also through reset; then answer requests one word at a time
  initial begin
    hstb_n = 1'b1;
    dmack_n = 1'b1;
    oe_bad = 0;
    forever begin
      wait_n(1);
      if (slow) wait_n(4);
      if (drq === 1'b1 && bsy === 1'b0) begin
        strobe();
      end else if (dmarq === 1'b1) begin
        dmack_n = 1'b0;
        wait_n(3);
        strobe();
        if (!burst) dmack_n = 1'b1;
      end else if (!burst) begin
        dmack_n = 1'b1;
      end
    end
  end
endmodule : datp_host

// File: tb/testbench.sv
// Self-checking bench for the data port byte lane block
`timescale 1ns/10ps

module testbench;
  logic clk, srst, blk_start, blk_ascii, in_valid, in_ready, burst, slow;
  logic [15:0] blk_len, dd_out;
  logic [7:0] in_byte;
  logic hstb_n, dmack_n, dd_oe_n, bsy, drq, dmarq, blk_done, char_err;
  datp_pkg::datp_mode_t blk_mode;
  int num_errors = 0;
  int samples_checked = 0;

  datp_port uut (
    .clk(clk), .srst(srst), .blk_start(blk_start), .blk_len(blk_len),
    .blk_mode(blk_mode), .blk_ascii(blk_ascii), .in_byte(in_byte),
    .in_valid(in_valid), .in_ready(in_ready), .hstb_n(hstb_n), .dmack_n(dmack_n),
    .dd_out(dd_out), .dd_oe_n(dd_oe_n), .bsy(bsy), .drq(drq), .dmarq(dmarq),
    .blk_done(blk_done), .char_err(char_err)
  );

  datp_host host (
    .clk(clk), .dd_out(dd_out), .dd_oe_n(dd_oe_n), .bsy(bsy), .drq(drq),
    .dmarq(dmarq), .hstb_n(hstb_n), .dmack_n(dmack_n), .burst(burst), .slow(slow)
  );

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic step();
    @(posedge clk);
    #1;
  endtask : step

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out

  // Sends one block, works out the words the host must see, compares them
  task automatic run_block(input datp_pkg::datp_mode_t m, input logic asc,
                           input logic [7:0] b[$]);
    logic [7:0] c[$];
    logic [15:0] e[$];
    int i;
    int k;
    foreach (b[j]) c.push_back((asc && (b[j] < 8'h20 || b[j] > 8'h7e)) ? 8'h20 : b[j]);
    if (m == datp_pkg::DATP_MODE_PIO8) begin
      foreach (c[j]) e.push_back({8'h00, c[j]});
    end else begin
      if (c.size() % 2) c.push_back(asc ? 8'h20 : 8'h00);
      for (i = 0; i < c.size(); i += 2) e.push_back(asc ? {c[i], c[i+1]} : {c[i+1], c[i]});
    end
    host.got.delete();
    blk_mode = m;
    blk_ascii = asc;
    blk_len = 16'(b.size());
    blk_start = 1'b1;
    step();
    blk_start = 1'b0;
    foreach (b[j]) begin
      in_byte = b[j];
      in_valid = 1'b1;
      for (k = 0; k < 2000 && in_ready !== 1'b1; k++) step();
      step();
    end
    in_valid = 1'b0;
    for (k = 0; k < 2000 && blk_done !== 1'b1; k++) step();
    chk("blk_done", 16'h1, {15'h0, blk_done});
    chk("word count", 16'(e.size()), 16'(host.got.size()));
    foreach (e[j]) chk("word", e[j], host.got[j]);
    chk("oe off at strobe", 16'h0, 16'(host.oe_bad));
    chk("idle bsy drq dmarq oe", 16'h9, {12'h0, bsy, drq, dmarq, dd_oe_n});
  endtask : run_block

  task automatic t_pio();
    run_block(datp_pkg::DATP_MODE_PIO16, 1'b0, '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55});
    slow = 1'b1;
    run_block(datp_pkg::DATP_MODE_PIO8, 1'b0, '{8'ha1, 8'hb2, 8'hc3});
    slow = 1'b0;
    $display("test pio done");
  endtask : t_pio

  task automatic t_dma();
    burst = 1'b1;
    run_block(datp_pkg::DATP_MODE_DMA, 1'b0, '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06});
    burst = 1'b0;
    run_block(datp_pkg::DATP_MODE_DMA, 1'b0, '{8'h9a, 8'hbc});
    $display("test dma done");
  endtask : t_dma

  task automatic t_ascii();
    run_block(datp_pkg::DATP_MODE_PIO16, 1'b1, '{"C", "o", 8'h7f, "y", 8'h10});
    chk("char_err", 16'h1, {15'h0, char_err});
    $display("test ascii done");
  endtask : t_ascii

  // Empty block refused, then a one byte block starting from index zero
  task automatic t_one();
    blk_len = 16'h0000;
    blk_start = 1'b1;
    step();
    blk_start = 1'b0;
    step();
    step();
    chk("in_ready len 0", 16'h0, {15'h0, in_ready});
    run_block(datp_pkg::DATP_MODE_PIO16, 1'b0, '{8'h5a});
    chk("char_err cleared", 16'h0, {15'h0, char_err});
    $display("test one byte done");
  endtask : t_one

  // Main sequence
  initial begin
    srst = 1'b1;
    {blk_start, blk_ascii, in_valid, burst, slow} = 5'h00;
    blk_len = 16'h0000;
    in_byte = 8'h00;
    blk_mode = datp_pkg::DATP_MODE_PIO16;
    repeat (2) @(posedge clk);
    #1;
    chk("reset status", 16'h0048, {9'h0, bsy, drq, dmarq, dd_oe_n, in_ready, blk_done, char_err});
    chk("reset dd_out", 16'h0000, dd_out);
    srst = 1'b0;
    t_pio();
    t_dma();
    t_ascii();
    t_one();
    close_out();
  end

  // Watchdog
  initial begin
    #100000;
    num_errors++;
    close_out();
  end
endmodule : testbench
